// ### bench/lemon_chk_assertions.sv
module lemon_chk
	import lemon_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic tx_done_level,
	input wire logic tx_abort_level,
	input wire logic ack_sym_level,
	input wire logic crc_err_level,
	input wire logic mcast_sym_level,
	input wire logic tx_done,
	input wire logic tx_abort,
	input wire logic ack_sent,
	input wire logic crc_fail,
	input wire logic mcast_event,
	input wire logic [23:0] response_timeout
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_done_src; tx_done |-> $past(tx_done_level) && !$past(tx_done_level, 2); endproperty
	a_done_src: assert property (p_done_src) else $error("done pulse without a fresh rise");
	property p_done_excl; tx_done |-> !tx_abort; endproperty
	a_done_excl: assert property (p_done_excl) else $error("done and abort together");
	property p_abort; $rose(tx_abort_level) && $past(presetn, 2) |=> tx_abort ##1 !tx_abort; endproperty
	a_abort: assert property (p_abort) else $error("abort pulse wrong");
	property p_ack; $rose(ack_sym_level) && $past(presetn, 2) |=> ack_sent ##1 !ack_sent; endproperty
	a_ack: assert property (p_ack) else $error("ack pulse wrong");
	property p_crc; crc_fail |-> $past(crc_err_level) && !$past(crc_err_level, 2); endproperty
	a_crc: assert property (p_crc) else $error("checksum pulse without a fresh rise");
	property p_mcast; $rose(mcast_sym_level) && $past(presetn, 2) |=> mcast_event ##1 !mcast_event; endproperty
	a_mcast: assert property (p_mcast) else $error("multicast pulse wrong");
	property p_wait; $changed(response_timeout) |-> $past(psel && penable && pwrite && paddr == LEMON_OFF_WAIT);
	endproperty
	a_wait: assert property (p_wait) else $error("timeout moved without a write");
	// async reset, so no disable here
	property p_rst; disable iff (1'b0) !presetn |-> !tx_done && !tx_abort && !crc_fail && !mcast_event; endproperty
	a_rst: assert property (p_rst) else $error("pulse during reset");
endmodule : lemon_chk
bind lemon_monitor lemon_chk lemon_chk_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .tx_done_level,
	.tx_abort_level, .ack_sym_level, .crc_err_level, .mcast_sym_level, .tx_done, .tx_abort, .ack_sent, .crc_fail,
	.mcast_event, .response_timeout);

// ### bench/lemon_user.sv
module lemon_user #(
	parameter logic [15:0] PTR = 16'h5a3c
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [8:0] pul,
	output logic [15:0] next_block_pointer_in,
	output logic [7:0] cnt [9]
);
	timeunit 1ns;
	timeprecision 1ps;
	assign next_block_pointer_in = PTR;
	// counting shows doubled or lost pulses
	always_ff @(posedge pclk or negedge presetn) begin
		for (int i = 0; i < 9; i++) begin
			if (!presetn) cnt[i] <= '0;
			else cnt[i] <= cnt[i] + 8'(pul[i]);
		end
	end
endmodule : lemon_user

// ### bench/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import lemon_pkg::*;
	localparam logic [15:0] PTR = 16'h5a3c;
	logic pclk = '0, presetn = '1, psel = '0, penable = '0, pwrite = '0, tx_block_taken = '0, tx_block_freed = '0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd;
	logic [8:0] lev = 9'h100, rx_free_blocks = 9'h030;
	wire [8:0] pul;
	logic pready, pslverr, irq, er, rx_space_flag_level_zero, rx_space_flag_level_one;
	logic rx_space_flag_level_two, rx_space_flag_level_three;
	logic [15:0] next_block_pointer_in;
	logic [7:0] tx_free_level;
	logic [23:0] response_timeout;
	logic [7:0] cnt [9];
	int errors = 0, n_compared = 0;
	always #5 pclk = ~pclk;
	lemon_monitor lemon_monitor_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .tx_done_level(lev[0]), .tx_abort_level(lev[1]), .ack_sym_level(lev[2]),
		.retry_sym_level(lev[3]), .nack_sym_level(lev[4]), .crc_err_level(lev[5]), .bad_sym_level(lev[6]),
		.bad_code_level(lev[7]), .mcast_sym_level(lev[8]), .tx_block_taken, .tx_block_freed, .rx_free_blocks,
		.next_block_pointer_in, .tx_free_level, .tx_done(pul[0]), .tx_abort(pul[1]), .ack_sent(pul[2]),
		.retry_sent(pul[3]), .nack_sent(pul[4]), .crc_fail(pul[5]), .bad_symbol(pul[6]), .bad_code(pul[7]),
		.mcast_event(pul[8]), .rx_space_flag_level_zero, .rx_space_flag_level_one, .rx_space_flag_level_two,
		.rx_space_flag_level_three, .response_timeout);
	lemon_user #(.PTR(PTR)) lemon_user_inst (.pclk, .presetn, .pul, .next_block_pointer_in, .cnt);
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		n_compared++;
		if (s !== x) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 64);
		if (pready !== 1'h1) errors++;
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask : apb
	task automatic wrap_up();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : wrap_up
	// run is under two hundred cycles
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		wrap_up();
	end
	initial begin
		// a real falling edge so the async resets fire at time zero
		presetn <= 1'h0;
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		repeat (4) @(posedge pclk);
		chk("held level", cnt[8], 32'h0);
		lev <= 9'h000;
		apb(1'h0, LEMON_OFF_HEADER, 32'h0, rd, er);
		chk("header", rd, {PTR, LEMON_EXT_FEAT_ID});
		apb(1'h0, LEMON_OFF_WAIT, 32'h0, rd, er);
		chk("wait reset", rd, {LEMON_WAIT_RST, 8'h00});
		chk("timeout reset", response_timeout, LEMON_WAIT_RST);
		apb(1'h1, LEMON_OFF_WAIT, 32'h1234_5678, rd, er);
		chk("timeout", response_timeout, 24'h12_3456);
		chk("level width", $bits(lemon_monitor_inst.tx_free_level), 32'd8);
		chk("free reset", tx_free_level, 8'hff);
		tx_block_taken <= 1'h1;
		repeat (3) @(posedge pclk);
		tx_block_taken <= 1'h0;
		@(posedge pclk);
		chk("free taken", tx_free_level, 8'hfc);
		apb(1'h0, LEMON_OFF_TX_FREE, 32'h0, rd, er);
		chk("free reg", rd, 32'h0000_00fc);
		tx_block_freed <= 1'h1;
		repeat (5) @(posedge pclk);
		tx_block_freed <= 1'h0;
		@(posedge pclk);
		chk("free saturate", tx_free_level, 8'hff);
		chk("flags", {rx_space_flag_level_three, rx_space_flag_level_two, rx_space_flag_level_one,
			rx_space_flag_level_zero}, 32'h7);
		apb(1'h1, LEMON_OFF_IRQ_MASK, 32'h0000_01ff, rd, er);
		for (int i = 0; i < 9; i++) begin
			lev[i] <= 1'h1;
			repeat (4) @(posedge pclk);
			lev[i] <= 1'h0;
			repeat (2) @(posedge pclk);
			apb(1'h0, LEMON_OFF_IRQ_STAT, 32'h0, rd, er);
			chk("status", rd, 32'h1 << i);
			chk("irq set", irq, 32'h1);
			apb(1'h1, LEMON_OFF_IRQ_STAT, 32'h1 << i, rd, er);
			@(posedge pclk);
			chk("irq clear", irq, 32'h0);
			chk("pulse count", cnt[i], 32'h1);
		end
		// cancel beats completion on the same edge
		lev[1:0] <= 2'h3;
		repeat (3) @(posedge pclk);
		lev <= 9'h000;
		repeat (3) @(posedge pclk);
		chk("done count", cnt[0], 32'h1);
		chk("abort count", cnt[1], 32'h2);
		apb(1'h1, LEMON_OFF_IRQ_STAT, 32'h0000_01ff, rd, er);
		apb(1'h1, LEMON_OFF_IRQ_MASK, 32'h0, rd, er);
		lev[5] <= 1'h1;
		repeat (3) @(posedge pclk);
		lev <= 9'h000;
		repeat (3) @(posedge pclk);
		chk("irq masked", irq, 32'h0);
		apb(1'h0, LEMON_OFF_IRQ_STAT, 32'h0, rd, er);
		chk("masked status", rd, 32'h0000_0020);
		apb(1'h0, 12'hffc, 32'h0, rd, er);
		chk("unmapped", er, 32'h1);
		wrap_up();
	end
endmodule : testbench

// ### core/lemon_monitor.sv
// What this block does
// - free level width log2(bytes/64)
// - free level counts free 64-byte blocks
// - one-cycle pulse per finished packet not cancelled on the same edge
// - one-cycle pulse per cancelled packet
// - pulse while packet-accepted symbol sent
// - pulse while packet-retry symbol sent
// - pulse while not-accepted symbol sent
// - pulse on received packet checksum error
// - pulse on corrupted received control symbol
// - pulse on invalid or illegal character
// - pulse on received multicast symbol
// - four buffer flags, one per threshold
// - pointer input forms header upper half
// - timeout output mirrors register bits 31:8
module lemon_monitor
	import lemon_pkg::*;
#(
	parameter int TX_BUF_BYTES = LEMON_TX_BUF_BYTES,
	parameter int RX_LW = 9
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic tx_done_level,
	input wire logic tx_abort_level,
	input wire logic ack_sym_level,
	input wire logic retry_sym_level,
	input wire logic nack_sym_level,
	input wire logic crc_err_level,
	input wire logic bad_sym_level,
	input wire logic bad_code_level,
	input wire logic mcast_sym_level,
	input wire logic tx_block_taken,
	input wire logic tx_block_freed,
	input wire logic [RX_LW-1:0] rx_free_blocks,
	input wire logic [15:0] next_block_pointer_in,
	output logic [$clog2(TX_BUF_BYTES/LEMON_BLOCK_BYTES)-1:0] tx_free_level,
	output logic tx_done,
	output logic tx_abort,
	output logic ack_sent,
	output logic retry_sent,
	output logic nack_sent,
	output logic crc_fail,
	output logic bad_symbol,
	output logic bad_code,
	output logic mcast_event,
	output logic rx_space_flag_level_zero,
	output logic rx_space_flag_level_one,
	output logic rx_space_flag_level_two,
	output logic rx_space_flag_level_three,
	output logic [23:0] response_timeout
);
	localparam int TXB = TX_BUF_BYTES / LEMON_BLOCK_BYTES;
	localparam int TXW = $clog2(TXB);
	if (TXB < 2 || (1 << TXW) != TXB || TX_BUF_BYTES % LEMON_BLOCK_BYTES != 0) begin : g_bad_txb
		$error("tx buffer size must be a power of two times 64, at least 128");
	end
	if (RX_LW < 1 || RX_LW > 24) begin : g_bad_rxlw
		$error("rx level width out of range");
	end

	logic [23:0] wait_q;
	logic [LEMON_NUM_EVT-1:0] stat_q, stat_d, mask_q;
	logic [31:0] thr_q;
	logic [TXW-1:0] tx_free_q, tx_free_d;
	logic [31:0] rdata_d;
	logic [LEMON_NUM_EVT-1:0] levels, pulses;
	lemon_tx_state_t tx_st_q, tx_st_d;

	// apb decode: zero wait, every access ends in its access phase
	wire logic acc = psel & penable;
	wire logic wr = acc & pwrite;
	wire logic hit_hdr = paddr == LEMON_OFF_HEADER;
	wire logic hit_wait = paddr == LEMON_OFF_WAIT;
	wire logic hit_stat = paddr == LEMON_OFF_IRQ_STAT;
	wire logic hit_mask = paddr == LEMON_OFF_IRQ_MASK;
	wire logic hit_txf = paddr == LEMON_OFF_TX_FREE;
	wire logic hit_thr = paddr == LEMON_OFF_RX_CFG;
	wire logic hit_rxf = paddr == LEMON_OFF_RX_FREE;
	wire logic mapped = hit_hdr | hit_wait | hit_stat | hit_mask | hit_txf | hit_thr | hit_rxf;
	// read-only header and level registers ignore writes without error
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	wire logic [31:0] header_word = {next_block_pointer_in, LEMON_EXT_FEAT_ID};

	always_comb begin
		rdata_d = 32'h0000_0000;
		if (hit_hdr)
			rdata_d = header_word;
		if (hit_wait)
			rdata_d = {wait_q, 8'h00};
		if (hit_stat)
			rdata_d = {{(32-LEMON_NUM_EVT){1'b0}}, stat_q};
		if (hit_mask)
			rdata_d = {{(32-LEMON_NUM_EVT){1'b0}}, mask_q};
		if (hit_txf)
			rdata_d = {{(32-TXW){1'b0}}, tx_free_q};
		if (hit_thr)
			rdata_d = thr_q;
		if (hit_rxf)
			rdata_d = {{(32-RX_LW){1'b0}}, rx_free_blocks};
	end
	assign prdata = acc & ~pwrite ? rdata_d : 32'h0000_0000;

	assign levels = {mcast_sym_level, bad_code_level, bad_sym_level, crc_err_level, nack_sym_level,
		retry_sym_level, ack_sym_level, tx_abort_level, tx_done_level};

	lemon_pulse #(.WIDTH(LEMON_NUM_EVT)) u_pulse (
		.pclk(pclk),
		.presetn(presetn),
		.level_in(levels),
		.pulse_out(pulses)
	);

	// tx packet tracking: the state is kept but does not gate done and abort, which count in any state
	wire logic tx_end = pulses[LEMON_EV_TX_DONE] | pulses[LEMON_EV_TX_ABORT];
	always_comb begin
		tx_st_d = tx_st_q;
		unique case (tx_st_q)
			LEMON_TX_IDLE: if (tx_block_taken) tx_st_d = LEMON_TX_SEND;
			LEMON_TX_SEND: if (tx_end) tx_st_d = LEMON_TX_IDLE;
			default: tx_st_d = LEMON_TX_IDLE;
		endcase
	end

	assign tx_done = pulses[LEMON_EV_TX_DONE] & ~pulses[LEMON_EV_TX_ABORT];
	assign tx_abort = pulses[LEMON_EV_TX_ABORT];
	assign ack_sent = pulses[LEMON_EV_ACK];
	assign retry_sent = pulses[LEMON_EV_RETRY];
	assign nack_sent = pulses[LEMON_EV_NACK];
	assign crc_fail = pulses[LEMON_EV_CRC];
	assign bad_symbol = pulses[LEMON_EV_SYM];
	assign bad_code = pulses[LEMON_EV_CODE];
	assign mcast_event = pulses[LEMON_EV_MCAST];

	// free block count, saturating both ways
	always_comb begin
		tx_free_d = tx_free_q;
		if (tx_block_taken & ~tx_block_freed & (tx_free_q != '0))
			tx_free_d = tx_free_q - 1'b1;
		else if (tx_block_freed & ~tx_block_taken & (tx_free_q != '1))
			tx_free_d = tx_free_q + 1'b1;
	end
	// full buffer is TXB blocks but the field tops out at TXB-1
	assign tx_free_level = tx_free_q;

	logic [3:0] avail;
	lemon_thresh #(.LW(RX_LW)) u_thresh (
		.pclk(pclk),
		.presetn(presetn),
		.free_blocks(rx_free_blocks),
		.thresholds(thr_q),
		.avail(avail)
	);
	assign rx_space_flag_level_zero = avail[0];
	assign rx_space_flag_level_one = avail[1];
	assign rx_space_flag_level_two = avail[2];
	assign rx_space_flag_level_three = avail[3];

	// set wins over write-one-to-clear
	wire logic [LEMON_NUM_EVT-1:0] evt = {mcast_event, bad_code, bad_symbol, crc_fail, nack_sent, retry_sent,
		ack_sent, tx_abort, tx_done};
	wire logic [LEMON_NUM_EVT-1:0] clr = (wr & hit_stat) ? pwdata[LEMON_NUM_EVT-1:0] : '0;
	assign stat_d = (stat_q & ~clr) | evt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q <= LEMON_WAIT_RST;
			stat_q <= '0;
			mask_q <= LEMON_MASK_RST;
			thr_q <= LEMON_RX_THR_RST;
			tx_free_q <= '1;
			tx_st_q <= LEMON_TX_IDLE;
		end else begin
			stat_q <= stat_d;
			tx_free_q <= tx_free_d;
			tx_st_q <= tx_st_d;
			if (wr & hit_wait)
				wait_q <= pwdata[31:LEMON_WAIT_LSB];
			if (wr & hit_mask)
				mask_q <= pwdata[LEMON_NUM_EVT-1:0];
			if (wr & hit_thr)
				thr_q <= pwdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_d & mask_q);
		end
	end

	assign response_timeout = wait_q;
endmodule : lemon_monitor

// ### core/lemon_pulse.sv
module lemon_pulse
	import lemon_pkg::*;
#(
	parameter int WIDTH = 4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] level_in,
	output logic [WIDTH-1:0] pulse_out
);
	logic [WIDTH-1:0] prev_q;
	logic armed_q;

	// armed after reset so a level held through reset makes no pulse
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= '0;
			armed_q <= 1'b0;
			pulse_out <= '0;
		end else begin
			prev_q <= level_in;
			armed_q <= 1'b1;
			pulse_out <= armed_q ? (level_in & ~prev_q) : '0;
		end
	end
endmodule : lemon_pulse

// ### core/lemon_thresh.sv
module lemon_thresh
	import lemon_pkg::*;
#(
	parameter int LW = 9
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [LW-1:0] free_blocks,
	input wire logic [4*8-1:0] thresholds,
	output logic [3:0] avail
);
	genvar g;
	generate
		for (g = 0; g < LEMON_NUM_THR; g++) begin : g_thr
			wire logic hit;
			assign hit = {{(32-LW){1'b0}}, free_blocks} >= {24'h00_0000, thresholds[g*8 +: 8]};
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					avail[g] <= 1'b0;
				end else begin
					avail[g] <= hit;
				end
			end
		end
	endgenerate
endmodule : lemon_thresh

// ### pkg/lemon_pkg.sv
package lemon_pkg;
	// register byte offsets
	localparam logic [11:0] LEMON_OFF_HEADER = 12'h0100;
	localparam logic [11:0] LEMON_OFF_WAIT = 12'h0124;
	localparam logic [11:0] LEMON_OFF_IRQ_STAT = 12'h0200;
	localparam logic [11:0] LEMON_OFF_IRQ_MASK = 12'h0204;
	localparam logic [11:0] LEMON_OFF_TX_FREE = 12'h0208;
	localparam logic [11:0] LEMON_OFF_RX_CFG = 12'h020c;
	localparam logic [11:0] LEMON_OFF_RX_FREE = 12'h0210;
	// field positions and reset values
	localparam int LEMON_WAIT_LSB = 8;
	localparam int LEMON_PTR_LSB = 16;
	localparam logic [15:0] LEMON_EXT_FEAT_ID = 16'h0004;
	localparam logic [23:0] LEMON_WAIT_RST = 24'hff_ffff;
	localparam int LEMON_BLOCK_BYTES = 64;
	localparam int LEMON_TX_BUF_BYTES = 16384;
	localparam int LEMON_NUM_EVT = 9;
	localparam int LEMON_NUM_THR = 4;
	// status bit positions
	localparam int LEMON_EV_TX_DONE = 0;
	localparam int LEMON_EV_TX_ABORT = 1;
	localparam int LEMON_EV_ACK = 2;
	localparam int LEMON_EV_RETRY = 3;
	localparam int LEMON_EV_NACK = 4;
	localparam int LEMON_EV_CRC = 5;
	localparam int LEMON_EV_SYM = 6;
	localparam int LEMON_EV_CODE = 7;
	localparam int LEMON_EV_MCAST = 8;
	localparam logic [8:0] LEMON_MASK_RST = 9'h000;
	localparam logic [31:0] LEMON_RX_THR_RST = 32'h4030_2010;

	typedef enum logic [1:0] {
		LEMON_TX_IDLE = 2'b00,
		LEMON_TX_SEND = 2'b01
	} lemon_tx_state_t;
endpackage : lemon_pkg
